// >>> cfd_defines.vh
`ifndef CFD_DEFINES_VH
`define CFD_DEFINES_VH

// ------------------------------------------------------------
// register byte addresses
// ------------------------------------------------------------
`define CFD_ADDR_FAULT_SETUP   8'h00
`define CFD_ADDR_CELL_SETUP    8'h04
`define CFD_ADDR_DEVICE_SETUP  8'h08
`define CFD_ADDR_FAULT_STATUS  8'h0c
`define CFD_ADDR_UV_FAULT      8'h10
`define CFD_ADDR_WIRE_FAULT    8'h14
`define CFD_ADDR_IRQ_STATUS    8'h18
`define CFD_ADDR_IRQ_MASK      8'h1c

// ------------------------------------------------------------
// fields and reset values
// ------------------------------------------------------------
`define CFD_DEPTH_W            3
`define CFD_DEPTH_RESET        3'h3
`define CFD_FS_W               3
`define CFD_FS_UV              0
`define CFD_FS_SUPPLY          1
`define CFD_FS_WIRE            2
`define CFD_IRQ_W              4
`define CFD_IRQ_UV             0
`define CFD_IRQ_SUPPLY         1
`define CFD_IRQ_WIRE           2
`define CFD_IRQ_REPORT         3
`define CFD_ALWAYS_WIRE_INPUTS 2

// ------------------------------------------------------------
// bus responses
// ------------------------------------------------------------
`define CFD_RESP_OKAY          2'h0
`define CFD_RESP_SLVERR        2'h2

`endif

// >>> cfd_filter.v
`default_nettype none

// ------------------------------------------------------------
// per-cell consecutive-sample fault filter
// ------------------------------------------------------------
module cfd_filter #(
  parameter CELLS = 12,
  parameter IDX_W = 4,
  parameter CNT_W = 8
) (
  // clock and reset
  input  wire               core_clk,
  input  wire               reset,
  // control
  input  wire               clear_all,
  input  wire [CNT_W-1:0]   depth,
  // samples
  input  wire               sample_valid,
  input  wire [IDX_W-1:0]   sample_index,
  input  wire               sample_fail,
  input  wire [CELLS-1:0]   sample_skip,
  // result
  output reg  [CELLS-1:0]   trip
);

  genvar g;
  generate
    for (g = 0; g < CELLS; g = g + 1) begin : g_cell
      reg  [CNT_W-1:0] count;
      wire             hit;
      assign hit = sample_valid && (sample_index == g[IDX_W-1:0]) && !sample_skip[g];
      always @(posedge core_clk) begin
        if (reset || clear_all) begin
          count   <= {CNT_W{1'b0}};
          trip[g] <= 1'b0;
        end else begin
          trip[g] <= 1'b0;
          if (hit) begin
            if (!sample_fail) begin
              count <= {CNT_W{1'b0}};
            end else if (count < depth) begin
              count <= count + {{(CNT_W-1){1'b0}}, 1'b1};
              if (count + {{(CNT_W-1){1'b0}}, 1'b1} == depth) begin
                trip[g] <= 1'b1;
              end
            end
          end
        end
      end
    end
  endgenerate

endmodule

`default_nettype wire

// >>> cfd_core.v
// Functional notes
// - mask bit 0 means connected; undervoltage check skipped for unconnected cells.
// - undervoltage flagged only after programmed count of consecutive failing samples per cell.
// - filter depth field resets to 3'b011, eight samples.
// - first fault with status zero sends the status word unasked.
// - writing a different filter depth value clears every consecutive-fault count.
// - a passing undervoltage sample clears that cell's count.
// - supply/ground open flagged after programmed consecutive open samples on one cell.
// - a scan with no open condition clears the open count.
// - scan current select 1 picks 1mA, 0 picks 150uA.
// - inputs two to twelve skip open-wire check when mask bit is one.
// - inputs zero and one are always open-wire checked.
`include "cfd_defines.vh"
`default_nettype none

module cfd_core #(
  parameter CELLS = 12,
  parameter IDX_W = 4,
  parameter CNT_W = 8
) (
  // clock and reset
  input  wire                 core_clk,
  input  wire                 reset,
  // axi4-lite write address
  input  wire                 s_axi_awvalid,
  output wire                 s_axi_awready,
  input  wire [7:0]           s_axi_awaddr,
  // axi4-lite write data
  input  wire                 s_axi_wvalid,
  output wire                 s_axi_wready,
  input  wire [31:0]          s_axi_wdata,
  input  wire [3:0]           s_axi_wstrb,
  // axi4-lite write response
  output reg                  s_axi_bvalid,
  input  wire                 s_axi_bready,
  output reg  [1:0]           s_axi_bresp,
  // axi4-lite read address
  input  wire                 s_axi_arvalid,
  output wire                 s_axi_arready,
  input  wire [7:0]           s_axi_araddr,
  // axi4-lite read data
  output reg                  s_axi_rvalid,
  input  wire                 s_axi_rready,
  output reg  [31:0]          s_axi_rdata,
  output reg  [1:0]           s_axi_rresp,
  // cell voltage scan results
  input  wire                 cell_sample_valid,
  input  wire [IDX_W-1:0]     cell_sample_index,
  input  wire                 cell_undervoltage,
  input  wire                 supply_open,
  // wire scan results
  input  wire                 wire_scan_done,
  input  wire [CELLS:0]       wire_open,
  // analog controls
  output reg                  scan_current_select,
  output reg  [CELLS:0]       open_wire_enable,
  // unsolicited fault report
  output reg                  fault_report_valid,
  output reg  [`CFD_FS_W-1:0] fault_report_data,
  // interrupt
  output wire                 irq
);

  // ------------------------------------------------------------
  // registers
  // ------------------------------------------------------------
  reg [`CFD_DEPTH_W-1:0] fault_filter_depth_field;
  reg [CELLS-1:0]        cell_setup;
  reg [`CFD_FS_W-1:0]    fault_status;
  reg [CELLS-1:0]        uv_fault;
  reg [CELLS:0]          wire_fault;
  reg [`CFD_IRQ_W-1:0]   irq_status;
  reg [`CFD_IRQ_W-1:0]   irq_mask;

  // ------------------------------------------------------------
  // write channel capture
  // ------------------------------------------------------------
  reg        aw_held;
  reg [7:0]  aw_addr;
  reg        w_held;
  reg [31:0] w_data;
  reg [3:0]  w_strb;
  wire       wr_go;
  wire [31:0] wr_mask;
  wire [31:0] wr_bits;

  assign s_axi_awready = !aw_held && !s_axi_bvalid;
  assign s_axi_wready  = !w_held && !s_axi_bvalid;
  assign wr_go         = aw_held && w_held && !s_axi_bvalid;
  assign wr_mask       = {{8{w_strb[3]}}, {8{w_strb[2]}}, {8{w_strb[1]}}, {8{w_strb[0]}}};
  assign wr_bits       = w_data & wr_mask;

  always @(posedge core_clk) begin
    if (reset) begin
      aw_held <= 1'b0;
      aw_addr <= 8'h00;
      w_held  <= 1'b0;
      w_data  <= 32'h00000000;
      w_strb  <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end else if (wr_go) begin
        aw_held <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end else if (wr_go) begin
        w_held <= 1'b0;
      end
    end
  end

  // write decode strobes
  wire wr_depth  = wr_go && (aw_addr == `CFD_ADDR_FAULT_SETUP);
  wire wr_cell   = wr_go && (aw_addr == `CFD_ADDR_CELL_SETUP);
  wire wr_dev    = wr_go && (aw_addr == `CFD_ADDR_DEVICE_SETUP);
  wire wr_fs     = wr_go && (aw_addr == `CFD_ADDR_FAULT_STATUS);
  wire wr_uv     = wr_go && (aw_addr == `CFD_ADDR_UV_FAULT);
  wire wr_wire   = wr_go && (aw_addr == `CFD_ADDR_WIRE_FAULT);
  wire wr_istat  = wr_go && (aw_addr == `CFD_ADDR_IRQ_STATUS);
  wire wr_imask  = wr_go && (aw_addr == `CFD_ADDR_IRQ_MASK);
  wire wr_mapped = wr_depth || wr_cell || wr_dev || wr_fs || wr_uv || wr_wire ||
                   wr_istat || wr_imask;

  // ------------------------------------------------------------
  // write response
  // ------------------------------------------------------------
  always @(posedge core_clk) begin
    if (reset) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= `CFD_RESP_OKAY;
    end else if (wr_go) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_mapped ? `CFD_RESP_OKAY : `CFD_RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // configuration registers
  // ------------------------------------------------------------
  wire [`CFD_DEPTH_W-1:0] new_depth = wr_bits[`CFD_DEPTH_W-1:0];
  wire depth_changed = wr_depth && w_strb[0] && (new_depth != fault_filter_depth_field);

  always @(posedge core_clk) begin
    if (reset) begin
      fault_filter_depth_field <= `CFD_DEPTH_RESET;
      cell_setup               <= {CELLS{1'b0}};
      scan_current_select      <= 1'b0;
      irq_mask                 <= {`CFD_IRQ_W{1'b0}};
    end else begin
      if (wr_depth && w_strb[0]) begin
        fault_filter_depth_field <= new_depth;
      end
      if (wr_cell) begin
        cell_setup <= (cell_setup & ~wr_mask[CELLS-1:0]) | wr_bits[CELLS-1:0];
      end
      if (wr_dev && w_strb[0]) begin
        scan_current_select <= wr_bits[0];
      end
      if (wr_imask && w_strb[0]) begin
        irq_mask <= wr_bits[`CFD_IRQ_W-1:0];
      end
    end
  end

  // code n selects 2**n consecutive samples
  wire [CNT_W-1:0] depth_samples =
    {{(CNT_W-1){1'b0}}, 1'b1} << fault_filter_depth_field;

  // ------------------------------------------------------------
  // consecutive-fault filters
  // ------------------------------------------------------------
  wire [CELLS-1:0] uv_trip;
  wire [CELLS-1:0] supply_trip;

  cfd_filter #(
    .CELLS (CELLS),
    .IDX_W (IDX_W),
    .CNT_W (CNT_W)
  ) u_uv_filter (
    .core_clk     (core_clk),
    .reset        (reset),
    .clear_all    (depth_changed),
    .depth        (depth_samples),
    .sample_valid (cell_sample_valid),
    .sample_index (cell_sample_index),
    .sample_fail  (cell_undervoltage),
    .sample_skip  (cell_setup),
    .trip         (uv_trip)
  );

  cfd_filter #(
    .CELLS (CELLS),
    .IDX_W (IDX_W),
    .CNT_W (CNT_W)
  ) u_supply_filter (
    .core_clk     (core_clk),
    .reset        (reset),
    .clear_all    (depth_changed),
    .depth        (depth_samples),
    .sample_valid (cell_sample_valid),
    .sample_index (cell_sample_index),
    .sample_fail  (supply_open),
    .sample_skip  ({CELLS{1'b0}}),
    .trip         (supply_trip)
  );

  // ------------------------------------------------------------
  // open-wire enables
  // ------------------------------------------------------------
  genvar g;
  generate
    for (g = 0; g <= CELLS; g = g + 1) begin : g_wire_en
      if (g < `CFD_ALWAYS_WIRE_INPUTS) begin : g_always
        always @(posedge core_clk) begin
          if (reset) begin
            open_wire_enable[g] <= 1'b1;
          end else begin
            open_wire_enable[g] <= 1'b1;
          end
        end
      end else begin : g_masked
        always @(posedge core_clk) begin
          if (reset) begin
            open_wire_enable[g] <= 1'b1;
          end else begin
            open_wire_enable[g] <= !cell_setup[g-1];
          end
        end
      end
    end
  endgenerate

  wire [CELLS:0] wire_hits = wire_scan_done ? (wire_open & open_wire_enable) : {(CELLS+1){1'b0}};

  // ------------------------------------------------------------
  // fault registers, set wins over clear
  // ------------------------------------------------------------
  wire [`CFD_FS_W-1:0] fs_set;
  assign fs_set[`CFD_FS_UV]     = |uv_trip;
  assign fs_set[`CFD_FS_SUPPLY] = |supply_trip;
  assign fs_set[`CFD_FS_WIRE]   = |wire_hits;

  reg [`CFD_FS_W-1:0] next_fault_status;
  always @* begin
    next_fault_status = fault_status;
    if (wr_fs) begin
      next_fault_status = fault_status & ~wr_bits[`CFD_FS_W-1:0];
    end
    next_fault_status = next_fault_status | fs_set;
  end

  always @(posedge core_clk) begin
    if (reset) begin
      fault_status       <= {`CFD_FS_W{1'b0}};
      uv_fault           <= {CELLS{1'b0}};
      wire_fault         <= {(CELLS+1){1'b0}};
      fault_report_valid <= 1'b0;
      fault_report_data  <= {`CFD_FS_W{1'b0}};
    end else begin
      fault_status <= next_fault_status;
      uv_fault     <= (wr_uv ? (uv_fault & ~wr_bits[CELLS-1:0]) : uv_fault) | uv_trip;
      wire_fault   <= (wr_wire ? (wire_fault & ~wr_bits[CELLS:0]) : wire_fault) | wire_hits;
      fault_report_valid <= 1'b0;
      if ((fault_status == {`CFD_FS_W{1'b0}}) && (|fs_set)) begin
        fault_report_valid <= 1'b1;
        fault_report_data  <= next_fault_status;
      end
    end
  end

  // ------------------------------------------------------------
  // read channel
  // ------------------------------------------------------------
  assign s_axi_arready = !s_axi_rvalid;
  wire rd_go    = s_axi_arvalid && s_axi_arready;
  wire rd_istat = rd_go && (s_axi_araddr == `CFD_ADDR_IRQ_STATUS);

  always @(posedge core_clk) begin
    if (reset) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= 32'h00000000;
      s_axi_rresp  <= `CFD_RESP_OKAY;
    end else if (rd_go) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rresp  <= `CFD_RESP_OKAY;
      s_axi_rdata  <= 32'h00000000;
      if (s_axi_araddr == `CFD_ADDR_FAULT_SETUP) begin
        s_axi_rdata[`CFD_DEPTH_W-1:0] <= fault_filter_depth_field;
      end else if (s_axi_araddr == `CFD_ADDR_CELL_SETUP) begin
        s_axi_rdata[CELLS-1:0] <= cell_setup;
      end else if (s_axi_araddr == `CFD_ADDR_DEVICE_SETUP) begin
        s_axi_rdata[0] <= scan_current_select;
      end else if (s_axi_araddr == `CFD_ADDR_FAULT_STATUS) begin
        s_axi_rdata[`CFD_FS_W-1:0] <= fault_status;
      end else if (s_axi_araddr == `CFD_ADDR_UV_FAULT) begin
        s_axi_rdata[CELLS-1:0] <= uv_fault;
      end else if (s_axi_araddr == `CFD_ADDR_WIRE_FAULT) begin
        s_axi_rdata[CELLS:0] <= wire_fault;
      end else if (s_axi_araddr == `CFD_ADDR_IRQ_STATUS) begin
        s_axi_rdata[`CFD_IRQ_W-1:0] <= irq_status;
      end else if (s_axi_araddr == `CFD_ADDR_IRQ_MASK) begin
        s_axi_rdata[`CFD_IRQ_W-1:0] <= irq_mask;
      end else begin
        s_axi_rresp <= `CFD_RESP_SLVERR;
      end
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // interrupt status, cleared by read, set wins
  // ------------------------------------------------------------
  wire [`CFD_IRQ_W-1:0] irq_set;
  assign irq_set[`CFD_IRQ_UV]     = fs_set[`CFD_FS_UV];
  assign irq_set[`CFD_IRQ_SUPPLY] = fs_set[`CFD_FS_SUPPLY];
  assign irq_set[`CFD_IRQ_WIRE]   = wire_scan_done;
  assign irq_set[`CFD_IRQ_REPORT] = fault_report_valid;

  always @(posedge core_clk) begin
    if (reset) begin
      irq_status <= {`CFD_IRQ_W{1'b0}};
    end else begin
      irq_status <= (rd_istat ? {`CFD_IRQ_W{1'b0}} : irq_status) | irq_set;
    end
  end

  assign irq = |(irq_status & irq_mask);

endmodule

`default_nettype wire

// >>> cfd_core_asserts.sv
`default_nettype none
module cfd_core_asserts #(
  parameter CELLS = 12,
  parameter IDX_W = 4,
  parameter CNT_W = 8
) (
  // clock and reset
  input wire logic           core_clk,
  input wire logic           reset,
  // register bus
  input wire logic           s_axi_awvalid,
  input wire logic           s_axi_awready,
  input wire logic           s_axi_wvalid,
  input wire logic           s_axi_wready,
  input wire logic           s_axi_bvalid,
  input wire logic           s_axi_bready,
  input wire logic           s_axi_arvalid,
  input wire logic           s_axi_arready,
  input wire logic           s_axi_rvalid,
  input wire logic           s_axi_rready,
  input wire logic [31:0]    s_axi_rdata,
  // fault side
  input wire logic           cell_sample_valid,
  input wire logic           cell_undervoltage,
  input wire logic           supply_open,
  input wire logic           wire_scan_done,
  input wire logic [CELLS:0] open_wire_enable,
  input wire logic           fault_report_valid
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (reset);
  // cycles since the last failing sample or wire scan result
  logic [2:0] age;
  always_ff @(posedge core_clk) begin
    if (reset) age <= 3'h7;
    else if (wire_scan_done || (cell_sample_valid && (cell_undervoltage || supply_open)))
      age <= 3'h0;
    else if (age != 3'h7) age <= age + 3'h1;
  end
  sequence wr_taken;
    s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
  endsequence
  sequence rd_taken;
    s_axi_arvalid && s_axi_arready;
  endsequence
  // both halves are held for one cycle before the response is raised
  a_wr_answer: assert property (wr_taken |-> ##2 s_axi_bvalid)
    else $error("write not answered");
  a_rd_answer: assert property (rd_taken |=> s_axi_rvalid)
    else $error("read not answered");
  a_b_hold: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped");
  a_r_hold: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
    else $error("read data dropped");
  a_ar_block: assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read accepted while busy");
  a_aw_block: assert property (s_axi_bvalid |-> !s_axi_awready && !s_axi_wready)
    else $error("write accepted while busy");
  a_report_pulse: assert property (fault_report_valid |=> !fault_report_valid)
    else $error("report longer than one cycle");
  a_report_cause: assert property (fault_report_valid |-> age <= 3'h3)
    else $error("report without a fault");
  a_wire_low_fixed: assert property (open_wire_enable[1:0] == 2'b11)
    else $error("low inputs not wire checked");
endmodule
bind cfd_core cfd_core_asserts #(.CELLS(CELLS), .IDX_W(IDX_W), .CNT_W(CNT_W)) cfd_chk (.*);
`default_nettype wire

// >>> cfd_host.sv
`default_nettype none
module cfd_host (
  // clock
  input  wire logic        core_clk,
  // write channels
  output var  logic        s_axi_awvalid,
  input  wire logic        s_axi_awready,
  output var  logic [7:0]  s_axi_awaddr,
  output var  logic        s_axi_wvalid,
  input  wire logic        s_axi_wready,
  output var  logic [31:0] s_axi_wdata,
  output var  logic [3:0]  s_axi_wstrb,
  input  wire logic        s_axi_bvalid,
  output var  logic        s_axi_bready,
  input  wire logic [1:0]  s_axi_bresp,
  // read channels
  output var  logic        s_axi_arvalid,
  input  wire logic        s_axi_arready,
  output var  logic [7:0]  s_axi_araddr,
  input  wire logic        s_axi_rvalid,
  output var  logic        s_axi_rready,
  input  wire logic [31:0] s_axi_rdata,
  input  wire logic [1:0]  s_axi_rresp
);
  timeunit 1ns;
  timeprecision 1ps;
  // responses are always accepted, so bready and rready stay high
  initial begin
    {s_axi_awvalid, s_axi_awaddr, s_axi_wvalid, s_axi_wdata, s_axi_arvalid, s_axi_araddr} = '0;
    {s_axi_wstrb, s_axi_bready, s_axi_rready} = 6'h3f;
  end
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic ta, tw, got;
    got = 1'b0;
    @(posedge core_clk);
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'b1;
    s_axi_wvalid <= 1'b1;
    // no local limit: only the bench timeout ends a wait
    while (!got) begin
      @(negedge core_clk);
      ta = s_axi_awvalid && s_axi_awready;
      tw = s_axi_wvalid && s_axi_wready;
      got = s_axi_bvalid;
      r = s_axi_bresp;
      @(posedge core_clk);
      if (ta) s_axi_awvalid <= 1'b0;
      if (tw) s_axi_wvalid <= 1'b0;
    end
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ta, got;
    got = 1'b0;
    @(posedge core_clk);
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'b1;
    while (!got) begin
      @(negedge core_clk);
      ta = s_axi_arvalid && s_axi_arready;
      got = s_axi_rvalid;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge core_clk);
      if (ta) s_axi_arvalid <= 1'b0;
    end
  endtask
  // detail register first, then the summary status
  task automatic clr(input logic [7:0] a, input logic [31:0] bits, input logic [2:0] st);
    logic [1:0] r;
    if (a != 8'h00) wr(a, bits, r);
    wr(8'h0c, {29'h0, st}, r);
  endtask
endmodule
`default_nettype wire

// >>> tb.sv
`include "cfd_defines.vh"
`default_nettype none
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        core_clk = 1'b0, reset = 1'b1, cell_sample_valid = 1'b0;
  logic        cell_undervoltage = 1'b0, supply_open = 1'b0, wire_scan_done = 1'b0;
  logic [3:0]  cell_sample_index = 4'h0, s_axi_wstrb;
  logic [12:0] wire_open = 13'h0, open_wire_enable, m_wire;
  logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid;
  logic        s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
  logic        scan_current_select, fault_report_valid, irq;
  logic [7:0]  s_axi_awaddr, s_axi_araddr;
  logic [31:0] s_axi_wdata, s_axi_rdata, d, seed = 32'h5412;
  logic [1:0]  s_axi_bresp, s_axi_rresp, r;
  logic [2:0]  fault_report_data, m_st = 3'h0, rep_d = 3'h0, got_d = 3'h0;
  logic [11:0] m_uv = 12'h0, m_mask = 12'h0;
  logic [3:0]  m_irq = 4'h0;
  int          n_mismatch = 0, n_checks = 0, cyc = 0, dep = 8, n_rep = 0, got_rep = 0;
  int          cu[12], cs[12];
  cfd_core cfd_core_inst (.*);
  cfd_host cfd_host_inst (.*);
  always #25 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc <= cyc + 1;
    if (fault_report_valid === 1'b1) begin
      got_rep <= got_rep + 1;
      got_d <= fault_report_data;
    end
    if (cyc == 20000) begin
      n_mismatch = n_mismatch + 1;
      test_done();
    end
  end
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[ERR] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
    cfd_host_inst.rd(a, d, r);
    chk(d, exp);
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] v);
    cfd_host_inst.wr(a, v, r);
  endtask
  // model: a status bit rises, reporting the word if it was empty
  task automatic mark(input int b);
    if (m_st == 3'h0) begin
      n_rep++;
      rep_d = 3'h1 << b;
      m_irq[3] = 1'b1;
    end
    m_st[b] = 1'b1;
    m_irq[b] = 1'b1;
  endtask
  task automatic samp(input int i, input logic uv, input logic so);
    @(posedge core_clk);
    cell_sample_valid <= 1'b1;
    cell_sample_index <= i[3:0];
    cell_undervoltage <= uv;
    supply_open <= so;
    if (!m_mask[i] && !uv) cu[i] = 0;
    else if (!m_mask[i] && cu[i] < dep) begin
      cu[i]++;
      if (cu[i] == dep) begin
        m_uv[i] = 1'b1;
        mark(0);
      end
    end
    if (!so) cs[i] = 0;
    else if (cs[i] < dep) begin
      cs[i]++;
      if (cs[i] == dep) mark(1);
    end
  endtask
  task automatic settle;
    @(posedge core_clk);
    cell_sample_valid <= 1'b0;
    repeat (4) @(posedge core_clk);
  endtask
  task automatic chk_rep;
    chk(got_rep, n_rep);
    chk(got_d, rep_d);
  endtask
  task automatic test_done;
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (16) @(posedge core_clk);
    reset <= 1'b0;
    rdc(`CFD_ADDR_FAULT_SETUP, 32'h3);
    chk(open_wire_enable, 13'h1fff);
    wr(`CFD_ADDR_IRQ_MASK, 32'hf);
    $display("test reset done");
    for (int k = 0; k < 7; k++) begin
      samp(3, 1'b1, 1'b0);
      samp(5, 1'b1, 1'b0);
    end
    samp(3, 1'b0, 1'b0);
    repeat (8) samp(3, 1'b1, 1'b0);
    samp(5, 1'b1, 1'b0);
    settle;
    rdc(`CFD_ADDR_FAULT_STATUS, m_st);
    rdc(`CFD_ADDR_UV_FAULT, m_uv);
    chk_rep;
    @(negedge core_clk);
    chk(irq, 1'b1);
    rdc(`CFD_ADDR_IRQ_STATUS, m_irq);
    m_irq = 4'h0;
    @(negedge core_clk);
    chk(irq, 1'b0);
    cfd_host_inst.clr(`CFD_ADDR_UV_FAULT, m_uv, 3'h1);
    m_uv = 12'h0;
    m_st = 3'h0;
    rdc(`CFD_ADDR_FAULT_STATUS, 32'h0);
    $display("test undervoltage filter done");
    repeat (7) samp(6, 1'b1, 1'b0);
    settle;
    wr(`CFD_ADDR_FAULT_SETUP, 32'h2);
    wr(`CFD_ADDR_FAULT_SETUP, 32'h3);
    foreach (cu[j]) begin
      cu[j] = 0;
      cs[j] = 0;
    end
    samp(6, 1'b1, 1'b0);
    // drop the sample strobe so the register writes add no cell 6 samples
    settle;
    m_mask = 12'h010;
    wr(`CFD_ADDR_CELL_SETUP, 32'h10);
    repeat (8) samp(4, 1'b1, 1'b0);
    settle;
    rdc(`CFD_ADDR_UV_FAULT, m_uv);
    chk(open_wire_enable, {~m_mask[11:1], 2'b11});
    $display("test depth rewrite and mask done");
    wr(`CFD_ADDR_IRQ_MASK, 32'h0);
    repeat (4) samp(0, 1'b0, 1'b1);
    samp(0, 1'b0, 1'b0);
    repeat (8) samp(0, 1'b0, 1'b1);
    settle;
    rdc(`CFD_ADDR_FAULT_STATUS, m_st);
    chk_rep;
    @(negedge core_clk);
    chk(irq, 1'b0);
    wr(`CFD_ADDR_IRQ_MASK, 32'hf);
    @(negedge core_clk);
    chk(irq, 1'b1);
    cfd_host_inst.clr(8'h00, 32'h0, 3'h2);
    m_st = 3'h0;
    $display("test supply open done");
    wr(`CFD_ADDR_DEVICE_SETUP, 32'h1);
    @(negedge core_clk);
    chk(scan_current_select, 1'b1);
    seed = xs(seed);
    m_wire = seed[12:0] & {~m_mask[11:1], 2'b11};
    @(posedge core_clk);
    wire_open <= seed[12:0];
    wire_scan_done <= 1'b1;
    @(posedge core_clk);
    wire_scan_done <= 1'b0;
    if (m_wire != 13'h0) mark(2);
    m_irq[2] = 1'b1;
    repeat (4) @(posedge core_clk);
    rdc(`CFD_ADDR_FAULT_STATUS, m_st);
    rdc(`CFD_ADDR_WIRE_FAULT, m_wire);
    chk_rep;
    rdc(`CFD_ADDR_IRQ_STATUS, m_irq);
    @(negedge core_clk);
    chk(irq, 1'b0);
    $display("test wire scan done");
    cfd_host_inst.rd(8'h40, d, r);
    chk(r, `CFD_RESP_SLVERR);
    chk(d, 32'h0);
    wr(8'h44, 32'h1);
    chk(r, `CFD_RESP_SLVERR);
    $display("test unmapped done");
    test_done();
  end
endmodule
`default_nettype wire
